// file: logic/pxcsr_pkg.sv
// Constants for the proximity sensor configuration and status register bank.
// Assumes an 8-bit register address space reached through a byte register port.
package pxcsr_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_PULSE_CFG  = 8'h8e;
  localparam logic [7:0] ADDR_RECV_CFG   = 8'h8f;
  localparam logic [7:0] ADDR_REVISION   = 8'h91;
  localparam logic [7:0] ADDR_PART_ID    = 8'h92;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h93;
  localparam logic [7:0] ADDR_AUX_CFG    = 8'hab;

  // Reset values
  localparam logic [7:0] RST_PULSE_CFG   = 8'h4f;
  localparam logic [7:0] RST_RECV_CFG    = 8'h80;
  localparam logic [7:0] RST_AUX_CFG     = 8'h0c;
  localparam logic [7:0] RST_INT_STATUS  = 8'h00;

  // Writable bit masks; other bits are read-only zero
  localparam logic [7:0] WMASK_RECV_CFG  = 8'hff;
  localparam logic [7:0] WMASK_AUX_CFG   = 8'h9f;

  // Status bit positions
  localparam int BIT_SAT       = 6;
  localparam int BIT_PROX_INT  = 5;
  localparam int BIT_CAL_INT   = 3;
  localparam int BIT_ZERO_INT  = 2;
  localparam int BIT_SAT_REFL  = 1;
  localparam int BIT_SAT_AMB   = 0;
  localparam logic [7:0] STATUS_IMPL_MASK = 8'h6f;
  localparam logic [7:0] SAT_CAUSE_MASK   = 8'h03;

  // Aux configuration fields
  localparam int BIT_CLR_ON_READ = 7;
  localparam int BIT_SAI         = 4;

  // Field positions
  localparam int LEN_HI   = 7;
  localparam int LEN_LO   = 6;
  localparam int CNT_HI   = 5;
  localparam int GAIN_HI  = 7;
  localparam int GAIN_LO  = 6;
  localparam int DRV_HI   = 4;

  // Analogue scaling
  localparam logic [5:0] PULSE_BASE_US = 6'h04;
  localparam logic [7:0] DRIVE_STEP_MA = 8'h06;
  localparam logic [3:0] GAIN_UNITY    = 4'h1;
endpackage

// file: logic/pxcsr_flag_if.sv
// Carrier between the register bank and its status flag store.
// Assumes one clock domain; all signals are sampled on the bank clock.
interface pxcsr_flag_if;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic [7:0] flags;
  modport bank  (output set_mask, output clr_mask, input flags);
  modport store (input set_mask, input clr_mask, output flags);
endinterface

// file: logic/pxcsr_flags.sv
// Sticky interrupt status flags with per-bit set and clear.
// Assumes set and clear masks are built by the register bank.
module pxcsr_flags
  import pxcsr_pkg::*;
(
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  rst,
  // Flag controls
  pxcsr_flag_if.store fl
);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // Set beats clear so a coincident event survives
      assign flags_nxt[i] = STATUS_IMPL_MASK[i] &
                            (fl.set_mask[i] | (flags_r[i] & ~fl.clr_mask[i]));
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r <= RST_INT_STATUS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fl.flags = flags_r;

  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
    (fl.set_mask[BIT_PROX_INT]) |=> flags_r[BIT_PROX_INT])
    else $error("Threshold event lost against a clear");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    (fl.clr_mask[BIT_CAL_INT] && !fl.set_mask[BIT_CAL_INT]) |=> !flags_r[BIT_CAL_INT])
    else $error("Calibration flag not cleared");
  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    (flags_r & ~STATUS_IMPL_MASK) == 8'h00)
    else $error("Reserved status bit set");
endmodule

// file: logic/pxcsr_top.sv
// Proximity sensor configuration and interrupt status register bank.
// Assumes a serial slave outside decodes bus cycles into byte read and
// write strobes, and the measurement engine supplies one-cycle events.
module pxcsr_top
  import pxcsr_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h1, // Arbitrary value
  parameter logic [5:0] PART_ID  = 6'h2a // Arbitrary value
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Measurement events
  input  wire logic       ev_sat_reflective,
  input  wire logic       ev_sat_ambient,
  input  wire logic       ev_prox_int,
  input  wire logic       ev_calib,
  input  wire logic       ev_zero,
  input  wire logic       prox_int_en,
  // Emitter and receiver settings
  output logic      [5:0] pulse_len_us,
  output logic      [6:0] pulse_count,
  output logic      [3:0] rx_gain,
  output logic      [7:0] led_drive_ma,
  output logic            sai_en,
  // Interrupt pin, open drain
  output logic            int_o,
  output logic            int_oe
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  pxcsr_flag_if fl ();

  logic [7:0] pulse_cfg_r;
  logic [7:0] recv_cfg_r;
  logic [7:0] aux_cfg_r;
  logic [7:0] rdata_r;
  logic [5:0] len_r;
  logic [6:0] cnt_r;
  logic [3:0] gain_r;
  logic [7:0] drv_r;
  logic       sai_r;
  logic       int_oe_r;

  wire logic       wr_pulse   = reg_wr && hit(reg_addr, ADDR_PULSE_CFG);
  wire logic       wr_recv    = reg_wr && hit(reg_addr, ADDR_RECV_CFG);
  wire logic       wr_aux     = reg_wr && hit(reg_addr, ADDR_AUX_CFG);
  wire logic       wr_status  = reg_wr && hit(reg_addr, ADDR_INT_STATUS);
  wire logic       rd_status  = reg_rd && hit(reg_addr, ADDR_INT_STATUS);
  wire logic       clr_on_rd  = aux_cfg_r[BIT_CLR_ON_READ];
  // Writing one to the general saturation bit also clears both causes
  wire logic [7:0] sat_clr    = reg_wdata[BIT_SAT] ? SAT_CAUSE_MASK : 8'h00;
  wire logic [7:0] wr_clr     = wr_status ? ((reg_wdata | sat_clr) & STATUS_IMPL_MASK)
                                          : 8'h00;
  wire logic [7:0] rd_clr     = (rd_status && clr_on_rd) ? STATUS_IMPL_MASK
                                                         : 8'h00;
  wire logic [7:0] aux_nxt    = (reg_wdata & WMASK_AUX_CFG) | (aux_cfg_r & ~WMASK_AUX_CFG);

  assign fl.clr_mask = wr_clr | rd_clr;
  assign fl.set_mask = {1'b0,
                        ev_sat_reflective | ev_sat_ambient,
                        ev_prox_int,
                        1'b0,
                        ev_calib,
                        ev_zero,
                        ev_sat_reflective,
                        ev_sat_ambient};

  // Read mux; unmapped and reserved bits return zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (1'b1)
      hit(reg_addr, ADDR_PULSE_CFG):  rd_mux = pulse_cfg_r;
      hit(reg_addr, ADDR_RECV_CFG):   rd_mux = recv_cfg_r;
      hit(reg_addr, ADDR_REVISION):   rd_mux = {5'h00, REVISION};
      hit(reg_addr, ADDR_PART_ID):    rd_mux = {PART_ID, 2'h0};
      hit(reg_addr, ADDR_INT_STATUS): rd_mux = fl.flags;
      hit(reg_addr, ADDR_AUX_CFG):    rd_mux = aux_cfg_r;
      default:                        rd_mux = 8'h00;
    endcase
  end

  wire logic [5:0] len_nxt  = PULSE_BASE_US << pulse_cfg_r[LEN_HI:LEN_LO];
  wire logic [6:0] cnt_nxt  = {1'b0, pulse_cfg_r[CNT_HI:0]} + 7'h01;
  wire logic [3:0] gain_nxt = GAIN_UNITY << recv_cfg_r[GAIN_HI:GAIN_LO];
  wire logic [7:0] drv_nxt  = 8'((16'({3'h0, recv_cfg_r[DRV_HI:0]}) + 16'h0001)
                                 * 16'(DRIVE_STEP_MA));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_cfg_r <= RST_PULSE_CFG;
      recv_cfg_r  <= RST_RECV_CFG;
      aux_cfg_r   <= RST_AUX_CFG;
    end else begin
      if (wr_pulse) pulse_cfg_r <= reg_wdata;
      if (wr_recv)  recv_cfg_r  <= reg_wdata & WMASK_RECV_CFG;
      if (wr_aux)   aux_cfg_r   <= aux_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r  <= 8'h00;
      len_r    <= 6'h00;
      cnt_r    <= 7'h00;
      gain_r   <= 4'h0;
      drv_r    <= 8'h00;
      sai_r    <= 1'b0;
      int_oe_r <= 1'b0;
    end else begin
      rdata_r  <= reg_rd ? rd_mux : rdata_r;
      len_r    <= len_nxt;
      cnt_r    <= cnt_nxt;
      gain_r   <= gain_nxt;
      drv_r    <= drv_nxt;
      sai_r    <= aux_cfg_r[BIT_SAI];
      int_oe_r <= fl.flags[BIT_PROX_INT] & prox_int_en;
    end
  end

  pxcsr_flags u_flags (
    .sys_clk (sys_clk),
    .rst     (rst),
    .fl      (fl.store)
  );

  assign reg_rdata    = rdata_r;
  assign pulse_len_us = len_r;
  assign pulse_count  = cnt_r;
  assign rx_gain      = gain_r;
  assign led_drive_ma = drv_r;
  assign sai_en       = sai_r;
  assign int_o        = 1'b0;
  assign int_oe       = int_oe_r;

  sequence s_wr_recv;
    reg_wr && hit(reg_addr, ADDR_RECV_CFG) && !rst;
  endsequence

  AST_GAIN: assert property (@(posedge sys_clk) disable iff (rst)
    s_wr_recv |-> ##2
      rx_gain == (GAIN_UNITY << $past(reg_wdata[GAIN_HI:GAIN_LO], 2)))
    else $error("Gain does not follow written code");
  AST_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
    s_wr_recv |-> ##2
      led_drive_ma == 8'(($past(reg_wdata[DRV_HI:0], 2) + 8'h01) * DRIVE_STEP_MA))
    else $error("LED current wrong");
  AST_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    wr_pulse |-> ##2 (pulse_count == 7'($past(reg_wdata[CNT_HI:0], 2)) + 7'h01 &&
      pulse_len_us == (PULSE_BASE_US << $past(reg_wdata[LEN_HI:LEN_LO], 2))))
    else $error("Pulse settings wrong");
  AST_READ_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_status && !clr_on_rd && !reg_wr && fl.flags[BIT_ZERO_INT]) |=> fl.flags[BIT_ZERO_INT])
    else $error("Read cleared flags with clear-on-read off");
  AST_READ_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_status && clr_on_rd && !ev_zero) |=> !fl.flags[BIT_ZERO_INT])
    else $error("Enabled read did not clear zero flag");
  AST_SAT_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_status && reg_wdata[BIT_SAT] && !ev_sat_reflective && !ev_sat_ambient)
      |=> fl.flags[BIT_SAT_REFL:BIT_SAT_AMB] == 2'b00)
    else $error("Saturation causes survived clear");
  AST_INT_PIN: assert property (@(posedge sys_clk) disable iff (rst)
    int_oe == $past(fl.flags[BIT_PROX_INT] && prox_int_en))
    else $error("Interrupt pin driven without enabled flag");
  AST_SAT_SET: assert property (@(posedge sys_clk) disable iff (rst)
    ev_sat_reflective |=> fl.flags[BIT_SAT] && fl.flags[BIT_SAT_REFL])
    else $error("Saturation event not flagged");
  AST_ID_RO: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && hit(reg_addr, ADDR_PART_ID)) |=> reg_rdata == {PART_ID, 2'h0})
    else $error("Part identity read wrong");

  // Threshold event, then enable held while the flag lands
  sequence s_prox_event;
    ev_prox_int ##1 prox_int_en;
  endsequence

  AST_PIN_WALK: assert property (@(posedge sys_clk) disable iff (rst)
    s_prox_event |=> int_oe)
    else $error("Interrupt pin missed an enabled threshold event");
  AST_PROX_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_status && reg_wdata[BIT_PROX_INT] && !ev_prox_int) |=> !fl.flags[BIT_PROX_INT])
    else $error("Threshold flag not cleared by write one");
  AST_CAL_SET: assert property (@(posedge sys_clk) disable iff (rst)
    ev_calib |=> fl.flags[BIT_CAL_INT])
    else $error("Calibration event not flagged");
  AST_ZERO_SET: assert property (@(posedge sys_clk) disable iff (rst)
    ev_zero |=> fl.flags[BIT_ZERO_INT])
    else $error("Zero detection event not flagged");
  AST_AMB_SET: assert property (@(posedge sys_clk) disable iff (rst)
    ev_sat_ambient |=> fl.flags[BIT_SAT] && fl.flags[BIT_SAT_AMB])
    else $error("Ambient saturation not flagged");
  AST_REV_RO: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && hit(reg_addr, ADDR_REVISION)) |=> reg_rdata == {5'h00, REVISION})
    else $error("Revision read wrong");
  AST_AUX_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && hit(reg_addr, ADDR_AUX_CFG)) |=> (reg_rdata & ~WMASK_AUX_CFG) == 8'h00)
    else $error("Reserved aux bits read nonzero");
  AST_RD_CLR_ALL: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_status && clr_on_rd && fl.set_mask == 8'h00) |=> fl.flags == 8'h00)
    else $error("Enabled status read left flags set");
endmodule

// file: tb/pxcsr_host.sv
// Host model: issues byte register reads and writes on the strobe port.
// Assumes the bench clock; drives only at falling edges.
module pxcsr_host (
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// file: tb/tb_top.sv
// Bench for the proximity register bank: register access and status flags.
// Assumes the host model drives the register port; events come from here.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pxcsr_pkg::*;
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  localparam logic [5:0] PID = 6'h13; // Arbitrary value
  logic sys_clk = 1'b0, rst = 1'b1, en = 1'b1;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, int_o, int_oe, sai_en;
  logic [4:0] ev = 5'h00;
  logic [5:0] len;
  logic [6:0] cnt;
  logic [3:0] gain;
  logic [7:0] drv;
  int err_count = 0, samples_checked = 0;
  pxcsr_top #(.REVISION(REV), .PART_ID(PID)) u_pxcsr_top (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
    .ev_sat_reflective(ev[4]), .ev_sat_ambient(ev[3]), .ev_prox_int(ev[2]),
    .ev_calib(ev[1]), .ev_zero(ev[0]), .prox_int_en(en), .pulse_len_us(len),
    .pulse_count(cnt), .rx_gain(gain), .led_drive_ma(drv), .sai_en(sai_en),
    .int_o(int_o), .int_oe(int_oe));
  pxcsr_host u_pxcsr_host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_pxcsr_host.rd(a, d);
    check(d, exp);
  endtask
  // One-cycle event pulse {reflective, ambient, threshold, calib, zero}
  task automatic pulse(input logic [4:0] m);
    @(negedge sys_clk);
    ev = m;
    @(negedge sys_clk);
    ev = 5'h00;
  endtask
  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    rchk(ADDR_PULSE_CFG, 8'h4f);
    rchk(ADDR_RECV_CFG, 8'h80);
    rchk(ADDR_AUX_CFG, 8'h0c);
    rchk(ADDR_INT_STATUS, 8'h00);
    check({2'b00, len}, 8'h08);
    check({1'b0, cnt}, 8'h10);
    check({gain, 4'h0} | 8'h00, 8'h40);
    check(drv, 8'h06);
    u_pxcsr_host.wr(ADDR_REVISION, 8'hff);
    u_pxcsr_host.wr(ADDR_PART_ID, 8'hff);
    rchk(ADDR_REVISION, {5'h00, REV});
    rchk(ADDR_PART_ID, {PID, 2'b00});
    rchk(8'h90, 8'h00);
    for (int c = 0; c < 4; c++) begin
      u_pxcsr_host.wr(ADDR_PULSE_CFG, {c[1:0], 6'h3f});
      u_pxcsr_host.wr(ADDR_RECV_CFG, {c[1:0], 1'b0, 5'h1f});
      settle();
      check({2'b00, len}, 8'h04 << c);
      check({1'b0, cnt}, 8'h40);
      check({4'h0, gain}, 8'h01 << c);
      check(drv, 8'hc0);
    end
    u_pxcsr_host.wr(ADDR_PULSE_CFG, 8'h00);
    u_pxcsr_host.wr(ADDR_RECV_CFG, 8'h01);
    settle();
    check({1'b0, cnt}, 8'h01);
    check(drv, 8'h0c);
    pulse(5'h1f);
    settle();
    check({int_o, int_oe}, 8'h01);
    rchk(ADDR_INT_STATUS, 8'h6f);
    u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h40);
    rchk(ADDR_INT_STATUS, 8'h2c);
    u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h20);
    settle();
    check({7'h00, int_oe}, 8'h00);
    rchk(ADDR_INT_STATUS, 8'h0c);
    u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h08);
    rchk(ADDR_INT_STATUS, 8'h04);
    u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h04);
    rchk(ADDR_INT_STATUS, 8'h00);
    pulse(5'h10);
    u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h02);
    rchk(ADDR_INT_STATUS, 8'h40);
    pulse(5'h08);
    u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h41);
    rchk(ADDR_INT_STATUS, 8'h00);
    en = 1'b0;
    pulse(5'h04);
    settle();
    check({7'h00, int_oe}, 8'h00);
    en = 1'b1;
    settle();
    check({7'h00, int_oe}, 8'h01);
    fork
      u_pxcsr_host.wr(ADDR_INT_STATUS, 8'h08);
      pulse(5'h02);
    join
    rchk(ADDR_INT_STATUS, 8'h28);
    u_pxcsr_host.wr(ADDR_AUX_CFG, 8'hff);
    rchk(ADDR_AUX_CFG, 8'h9f);
    check({7'h00, sai_en}, 8'h01);
    pulse(5'h01);
    rchk(ADDR_INT_STATUS, 8'h2c);
    rchk(ADDR_INT_STATUS, 8'h00);
    finish_test();
  end
endmodule
